// >>> verilog/hsf_bank.sv
// APB register bank for harmonic control, scale groups and the float set.
// Assumes an APB master on clk_sys_i and a harmonic engine on the same clock.
//
// Behaviour
// R1: Harmonic results cover orders up to the 31st for every metered value.
// R2: Refresh flag reads 0 while results refresh, 1 once all are new.
// R3: Results may stay frozen up to 60 metering update cycles after processing.
// R4: Mode 0 disables, 1 gives magnitudes, 2 magnitudes and angles.
// R5: Mode resets to magnitudes only.
// R6: Voltage format: 0 percent fundamental (default), 1 percent rms, 2 rms.
// R7: Current format: 0 percent fundamental (default), 1 percent rms, 2 rms.
// R8: Refresh interval holds 10 to 60 seconds, default 30.
// R9: Countdown shows seconds, 0 to 60, until the next harmonic update.
// R10: Completion reads 0 while processing, 1 when processing has finished.
// R11: Each metered quantity is a signed 16-bit integer within plus/minus 32767.
// R12: A scale factor is the base-ten exponent of the value multiplier.
// R13: One scale factor applies to every metered value of its group.
// R14: Master multiplies raw values by ten to the scale factor.
// R15: Master should reset min, max and peak demand after scale changes.
// R16: Float duplicate set exists and is disabled after reset.
// R17: Disabled float set returns -32768 from float phase A current.
// R18: Enter setup, enable float, save 1, exit setup activates the set.
// R19: Display keeps integer form even with the float set enabled.
// R20: Setup exit commits only when save register holds 1, else discards.
// R21: Setup idle over two minutes is abandoned, original values restored.
// R22: Only one setup session may be open at a time.
// R23: Out-of-range mode, format and interval writes are ignored.
//
// Our own choice: register access over APB.

`timescale 1ns/10ps
`default_nettype none

module hsf_bank
  import hsf_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `HSF_CLK_HZ * `HSF_TICK_PERIOD_S
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Harmonic engine
  input wire logic meter_cycle_i,
  input wire logic harm_done_i,
  output logic harm_start_o,
  output logic harm_freeze_o,
  output logic [1:0] harm_mode_o,
  output logic [1:0] v_fmt_o,
  output logic [1:0] i_fmt_o,
  output logic [4:0] harm_max_order_o,
  // Metering values and scale groups
  input wire logic signed [31:0] meas_ia_i,
  input wire logic [31:0] float_ia_i,
  output logic [15:0] scale_o,
  // Float set, display and setup
  input wire logic button_i,
  output logic float_active_o,
  output logic disp_int_fmt_o,
  output logic setup_open_o
);

  // ============================================================
  // Helpers
  function automatic logic [15:0] clamp16(input logic signed [31:0] v);
    if (v > `HSF_INT_MAX) begin
      clamp16 = 16'(`HSF_INT_MAX);
    end else if (v < `HSF_INT_MIN) begin
      clamp16 = 16'(`HSF_INT_MIN);
    end else begin
      clamp16 = v[15:0];
    end
  endfunction

  function automatic logic is_scale(input logic [`HSF_IDX_W-1:0] idx);
    is_scale = (idx >= `HSF_IDX_SCALE0) &&
      (idx < `HSF_IDX_SCALE0 + `HSF_IDX_W'(`HSF_SCALE_GROUPS));
  endfunction

  hsf_state_t q;
  hsf_state_t d;
  logic [`HSF_IDX_W-1:0] idx;
  logic [15:0] wv;
  logic wr;
  logic tick;
  logic su_open;
  logic [1:0] scl;

  assign idx = paddr_i[15:2];
  assign wv = pwdata_i[15:0];
  assign scl = 2'(idx - `HSF_IDX_SCALE0);
  // Writes land at the edge that sees pready high
  assign wr = psel_i && penable_i && pwrite_i && q.pready;
  assign tick = (q.sec_cnt == 32'(SEC_CYCLES - 1));
  assign su_open = (q.su == HSF_SU_OPEN);

  // ============================================================
  // Next state
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.btn = {q.btn[1:0], button_i};
    d.sec_cnt = tick ? 32'h0000_0000 : q.sec_cnt + 32'h0000_0001;

    // Bus answer: decoded in setup, shown through the access phase
    d.pready = psel_i && !penable_i;
    d.pslverr = 1'b0;
    d.prdata = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (idx)
        `HSF_IDX_MODE: d.prdata[1:0] = su_open ? q.st_mode : q.mode;
        `HSF_IDX_VFMT: d.prdata[1:0] = su_open ? q.st_vfmt : q.vfmt;
        `HSF_IDX_CFMT: d.prdata[1:0] = su_open ? q.st_cfmt : q.cfmt;
        `HSF_IDX_INTERVAL: d.prdata[5:0] = su_open ? q.st_interval : q.interval;
        `HSF_IDX_CDOWN: d.prdata[5:0] = q.cdown; // R9
        `HSF_IDX_DONE: d.prdata[0] = q.done; // R10
        `HSF_IDX_RFLAG: d.prdata[0] = q.rflag; // R2
        `HSF_IDX_FEN: d.prdata[0] = su_open ? q.st_fen : q.fen;
        `HSF_IDX_HOLD: d.prdata[5:0] = su_open ? q.st_hold : q.hold;
        `HSF_IDX_IA_INT: d.prdata[15:0] = q.ia_int;
        `HSF_IDX_ORDER: d.prdata[4:0] = `HSF_MAX_ORDER; // R1
        `HSF_IDX_SAVE: d.prdata[15:0] = q.save;
        `HSF_IDX_CMD: d.prdata = 32'h0000_0000;
        // Sentinel until the set is enabled
        `HSF_IDX_FLOAT_IA: d.prdata = q.fen ? float_ia_i : `HSF_FLOAT_OFF; // R17
        default: begin
          if (is_scale(idx)) begin
            d.prdata[3:0] = su_open ? q.st_scale[scl] : q.scale[scl]; // R12
          end else begin
            d.pslverr = 1'b1;
          end
        end
      endcase
    end else if (psel_i && !penable_i && pwrite_i) begin
      d.pslverr = !(is_scale(idx) || idx == `HSF_IDX_MODE ||
        idx == `HSF_IDX_VFMT || idx == `HSF_IDX_CFMT ||
        idx == `HSF_IDX_INTERVAL || idx == `HSF_IDX_CDOWN ||
        idx == `HSF_IDX_DONE || idx == `HSF_IDX_RFLAG ||
        idx == `HSF_IDX_FEN || idx == `HSF_IDX_HOLD ||
        idx == `HSF_IDX_IA_INT || idx == `HSF_IDX_ORDER ||
        idx == `HSF_IDX_CMD || idx == `HSF_IDX_SAVE ||
        idx == `HSF_IDX_FLOAT_IA);
    end

    // Setup session: staged values are loaded on entry and change only while open
    if (su_open && (wr || (q.btn[1] && !q.btn[2]))) begin
      d.idle_cnt = 8'h00;
    end else if (su_open && tick) begin
      d.idle_cnt = q.idle_cnt + 8'h01;
    end
    if (wr) begin
      if (su_open) begin
        if (idx == `HSF_IDX_MODE && wv <= `HSF_SEL_MAX) begin
          d.st_mode = wv[1:0]; // R4 R23
        end
        if (idx == `HSF_IDX_VFMT && wv <= `HSF_SEL_MAX) begin
          d.st_vfmt = wv[1:0]; // R6 R23
        end
        if (idx == `HSF_IDX_CFMT && wv <= `HSF_SEL_MAX) begin
          d.st_cfmt = wv[1:0]; // R7 R23
        end
        if (idx == `HSF_IDX_INTERVAL && wv >= `HSF_INTERVAL_MIN &&
            wv <= `HSF_INTERVAL_MAX) begin
          d.st_interval = wv[5:0]; // R8 R23
        end
        if (idx == `HSF_IDX_HOLD && wv <= `HSF_HOLD_MAX) begin
          d.st_hold = wv[5:0]; // R3
        end
        if (idx == `HSF_IDX_FEN && wv <= `HSF_SAVE_YES) begin
          d.st_fen = wv[0]; // R18
        end
        if (is_scale(idx)) begin
          d.st_scale[scl] = wv[3:0]; // R13
        end
      end
      if (idx == `HSF_IDX_SAVE) begin
        d.save = wv;
      end
      if (idx == `HSF_IDX_CMD && wv == `HSF_CMD_ENTER && !su_open) begin
        // A second entry while open is ignored
        d.su = HSF_SU_OPEN; // R22
        d.save = 16'h0000;
        d.idle_cnt = 8'h00;
        d.st_mode = q.mode;
        d.st_vfmt = q.vfmt;
        d.st_cfmt = q.cfmt;
        d.st_interval = q.interval;
        d.st_hold = q.hold;
        d.st_fen = q.fen;
        d.st_scale = q.scale;
      end
      if (idx == `HSF_IDX_CMD && wv == `HSF_CMD_EXIT && su_open) begin
        d.su = HSF_SU_IDLE; // R20
        if (q.save == `HSF_SAVE_YES) begin
          d.mode = q.st_mode;
          d.vfmt = q.st_vfmt;
          d.cfmt = q.st_cfmt;
          d.interval = q.st_interval;
          d.hold = q.st_hold;
          d.fen = q.st_fen; // R18
          d.scale = q.st_scale; // R13
        end
      end
    end else if (su_open && tick && q.idle_cnt == `HSF_SETUP_TIMEOUT_S) begin
      // Committed copies were never touched, so dropping is a restore
      d.su = HSF_SU_IDLE; // R21
    end

    // Harmonic refresh timing
    if (tick) begin
      if (q.cdown == 6'h00) begin
        d.cdown = q.interval; // R9
        if (q.mode != HSF_HM_OFF && q.hp == HSF_HP_IDLE && q.hold_cnt == 6'h00) begin
          d.start = 1'b1;
          d.hp = HSF_HP_BUSY;
          d.done = 1'b0; // R10
          d.rflag = 1'b0; // R2
        end
      end else begin
        d.cdown = q.cdown - 6'h01;
      end
    end
    if (meter_cycle_i) begin
      d.ia_int = clamp16(meas_ia_i); // R11
      if (q.hold_cnt != 6'h00) begin
        d.hold_cnt = q.hold_cnt - 6'h01;
      end
    end
    // Completion set wins over a same-cycle clear
    if (harm_done_i && q.hp == HSF_HP_BUSY) begin
      d.hp = HSF_HP_IDLE;
      d.done = 1'b1; // R10
      d.rflag = 1'b1; // R2
      d.hold_cnt = q.hold; // R3
    end
    // Registered so the freeze output comes from a flop
    d.freeze = (d.hold_cnt != 6'h00); // R3
  end

  // ============================================================
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.mode <= HSF_HM_MAG; // R5
      q.st_mode <= HSF_HM_MAG;
      q.interval <= `HSF_INTERVAL_RST; // R8
      q.st_interval <= `HSF_INTERVAL_RST;
      q.cdown <= `HSF_INTERVAL_RST;
      q.su <= HSF_SU_IDLE;
      q.hp <= HSF_HP_IDLE;
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // Outputs
  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign harm_start_o = q.start;
  assign harm_freeze_o = q.freeze;
  assign harm_mode_o = q.mode;
  assign v_fmt_o = q.vfmt;
  assign i_fmt_o = q.cfmt;
  assign harm_max_order_o = `HSF_MAX_ORDER;
  assign scale_o = q.scale;
  assign float_active_o = q.fen; // R16
  // Display path never switches to float
  assign disp_int_fmt_o = 1'b1; // R19
  assign setup_open_o = su_open;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_mode_reset;
    $past(sys_rst_i) |-> q.mode == HSF_HM_MAG && !q.fen;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("bad reset mode"); // R5

  property p_mode_legal;
    q.mode != 2'h3 && q.st_mode != 2'h3 && q.vfmt != 2'h3 && q.cfmt != 2'h3;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal selector"); // R23

  property p_interval;
    q.interval >= 6'(`HSF_INTERVAL_MIN) && q.interval <= 6'(`HSF_INTERVAL_MAX);
  endproperty
  a_interval: assert property (p_interval) else $error("interval out of range"); // R8

  property p_start_clears;
    q.start |-> q.hp == HSF_HP_BUSY && q.cdown == $past(q.interval) && !harm_freeze_o;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("bad start"); // R9

  property p_refresh;
    harm_start_o && !harm_done_i |-> !q.rflag && !q.done;
  endproperty
  a_refresh: assert property (p_refresh) else $error("flags not cleared"); // R2

  property p_done;
    harm_done_i && q.hp == HSF_HP_BUSY |=> q.done && q.rflag &&
      q.hold_cnt == $past(q.hold);
  endproperty
  a_done: assert property (p_done) else $error("completion missed"); // R3

  property p_float_off;
    psel_i && !penable_i && !pwrite_i && idx == `HSF_IDX_FLOAT_IA && !q.fen
      |=> pready_o && prdata_o == `HSF_FLOAT_OFF;
  endproperty
  a_float_off: assert property (p_float_off) else $error("no float sentinel"); // R17

  property p_commit;
    wr && idx == `HSF_IDX_CMD && wv == `HSF_CMD_EXIT && su_open
      |=> !setup_open_o && (float_active_o == ($past(q.save) == `HSF_SAVE_YES ?
      $past(q.st_fen) : $past(q.fen)));
  endproperty
  a_commit: assert property (p_commit) else $error("bad setup exit"); // R20

  property p_single;
    wr && idx == `HSF_IDX_CMD && wv == `HSF_CMD_ENTER && su_open
      |=> setup_open_o && q.save == $past(q.save);
  endproperty
  a_single: assert property (p_single) else $error("second session opened"); // R22

  property p_clamp;
    q.ia_int != 16'h8000;
  endproperty
  a_clamp: assert property (p_clamp) else $error("integer out of range"); // R11

  c_commit: cover property (wr && idx == `HSF_IDX_CMD && wv == `HSF_CMD_EXIT &&
    su_open && q.save == `HSF_SAVE_YES);
  c_timeout: cover property (su_open && tick && q.idle_cnt == `HSF_SETUP_TIMEOUT_S);
  c_harm: cover property (harm_start_o ##[1:20] harm_done_i);

endmodule

`default_nettype wire

// >>> verilog/hsf_defs.svh
// Constants of the harmonic, scale and float configuration bank.
// Included by the package and the bench; holds definitions only.
`ifndef HSF_DEFS_SVH
`define HSF_DEFS_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define HSF_IDX_W 14
`define HSF_IDX_MODE 14'h0CA8
`define HSF_IDX_VFMT 14'h0CA9
`define HSF_IDX_CFMT 14'h0CAA
`define HSF_IDX_INTERVAL 14'h0CAB
`define HSF_IDX_CDOWN 14'h0CAC
`define HSF_IDX_DONE 14'h0CAD
`define HSF_IDX_RFLAG 14'h0CAE
`define HSF_IDX_FEN 14'h0CB0
`define HSF_IDX_HOLD 14'h0CB1
`define HSF_IDX_SCALE0 14'h0CB4
`define HSF_IDX_IA_INT 14'h0CB8
`define HSF_IDX_ORDER 14'h0CB9
`define HSF_IDX_CMD 14'h1F40
`define HSF_IDX_SAVE 14'h1F41
`define HSF_IDX_FLOAT_IA 14'h2DB4

// ============================================================
// Codes, limits and reset values
`define HSF_CMD_ENTER 16'h233C
`define HSF_CMD_EXIT 16'h233D
`define HSF_SAVE_YES 16'h0001
`define HSF_SEL_MAX 16'h0002
`define HSF_INTERVAL_MIN 16'h000A
`define HSF_INTERVAL_MAX 16'h003C
`define HSF_INTERVAL_RST 6'h1E
`define HSF_HOLD_MAX 16'h003C
`define HSF_FLOAT_OFF 32'h0000_8000
`define HSF_INT_MAX 32'sh0000_7FFF
`define HSF_INT_MIN (-32'sh0000_7FFF)
`define HSF_MAX_ORDER 5'h1F
`define HSF_SCALE_GROUPS 4

// ============================================================
// Timing
`define HSF_CLK_HZ 40000000
`define HSF_TICK_PERIOD_S 1
`define HSF_SETUP_TIMEOUT_S 8'd120

`endif

// >>> verilog/hsf_pkg.sv
// Types of the harmonic, scale and float configuration bank.
// Assumes hsf_defs.svh is on the include path.
`default_nettype none
`include "hsf_defs.svh"

package hsf_pkg;

  // ============================================================
  // Modes and states
  typedef enum logic [1:0] {HSF_HM_OFF, HSF_HM_MAG, HSF_HM_MAG_ANG} hsf_hmode_t;
  typedef enum logic {HSF_SU_IDLE, HSF_SU_OPEN} hsf_su_t;
  typedef enum logic {HSF_HP_IDLE, HSF_HP_BUSY} hsf_hp_t;
  typedef logic [`HSF_SCALE_GROUPS-1:0][3:0] hsf_scale_t;

  // ============================================================
  // Whole state of the bank
  typedef struct packed {
    hsf_su_t su;
    hsf_hp_t hp;
    logic [1:0] mode;
    logic [1:0] vfmt;
    logic [1:0] cfmt;
    logic [5:0] interval;
    logic [5:0] hold;
    logic fen;
    hsf_scale_t scale;
    logic [1:0] st_mode;
    logic [1:0] st_vfmt;
    logic [1:0] st_cfmt;
    logic [5:0] st_interval;
    logic [5:0] st_hold;
    logic st_fen;
    hsf_scale_t st_scale;
    logic [15:0] save;
    logic [5:0] cdown;
    logic done;
    logic rflag;
    logic [5:0] hold_cnt;
    logic freeze;
    logic [31:0] sec_cnt;
    logic [7:0] idle_cnt;
    logic [15:0] ia_int;
    logic [2:0] btn;
    logic start;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } hsf_state_t;

endpackage

`default_nettype wire

// >>> sim/hsf_apb_master.sv
// APB master model: the remote master that reads and writes the bank.
// Assumes one clock shared with the bank; the bench calls xfer.
`timescale 1ns/10ps
`default_nettype none

module hsf_apb_master (
  // Clock
  input wire logic clk_i,
  // APB master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [15:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 16'h0000;
    pwdata_o = 32'h0000_0000;
  end

  // ============================================================
  // One transfer; status 0 done, 1 slave error, 2 no answer
  task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
      output logic [31:0] rd, output int st);
    int n;
    st = 2;
    rd = 32'h0000_0000;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= {idx, 2'h0};
    pwdata_o <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    for (n = 0; n < 16 && st == 2; n++) begin
      @(posedge clk_i);
      if (pready_i === 1'b1) begin
        rd = prdata_i;
        st = (pslverr_i === 1'b1) ? 1 : 0;
      end
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released bus shows no stale data
    pwdata_o <= ~wd;
    paddr_o <= ~{idx, 2'h0};
  endtask
endmodule

`default_nettype wire

// >>> sim/harmonic_scale_float_config_test.sv
// Self-checking bench of the harmonic, scale and float bank.
// Assumes hsf_defs.svh on the include path and a short one-second tick.
`timescale 1ns/10ps
`default_nettype none
`include "hsf_defs.svh"
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
      err_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module harmonic_scale_float_config_test;
  localparam int SEC = 10;
  logic clk_sys_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic meter_cycle_i, harm_done_i, harm_start_o, harm_freeze_o;
  logic [1:0] harm_mode_o, v_fmt_o, i_fmt_o;
  logic [4:0] harm_max_order_o;
  logic signed [31:0] meas_ia_i;
  logic [31:0] float_ia_i;
  logic [15:0] scale_o;
  logic button_i, float_active_o, disp_int_fmt_o, setup_open_o;
  logic [31:0] seed = 32'h0000_ACBE;
  int err_count, comparisons, sts, r, k, n, idx, v, e, g;
  int cm[int];
  int st[int];
  int sv;
  bit op;
  int iv[3];

  hsf_bank #(.SEC_CYCLES(SEC)) u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .meter_cycle_i(meter_cycle_i), .harm_done_i(harm_done_i), .harm_start_o(harm_start_o),
    .harm_freeze_o(harm_freeze_o), .harm_mode_o(harm_mode_o), .v_fmt_o(v_fmt_o),
    .i_fmt_o(i_fmt_o), .harm_max_order_o(harm_max_order_o), .meas_ia_i(meas_ia_i),
    .float_ia_i(float_ia_i), .scale_o(scale_o), .button_i(button_i),
    .float_active_o(float_active_o), .disp_int_fmt_o(disp_int_fmt_o),
    .setup_open_o(setup_open_o));

  hsf_apb_master u_mst (.clk_i(clk_sys_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // ============================================================
  // Helpers and reference model
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic bit in_range(int i, int x);
    case (i)
      `HSF_IDX_INTERVAL: return x >= `HSF_INTERVAL_MIN && x <= `HSF_INTERVAL_MAX;
      `HSF_IDX_FEN: return x <= 1;
      `HSF_IDX_MODE, `HSF_IDX_VFMT, `HSF_IDX_CFMT: return x <= `HSF_SEL_MAX;
      default: return 1;
    endcase
  endfunction

  task automatic give_verdict();
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hung();
    if (sts == 2) begin
      err_count++;
      give_verdict();
    end
  endtask

  // Config writes land in the staged copy only while a session is open
  task automatic wr(input int i, input int x);
    u_mst.xfer(1'b1, i[13:0], x, rd, sts);
    hung();
    if (i == `HSF_IDX_CMD) begin
      if (x == `HSF_CMD_ENTER && !op) begin
        st = cm;
        sv = 0;
        op = 1;
      end else if (x == `HSF_CMD_EXIT && op) begin
        if (sv == 1) cm = st;
        op = 0;
      end
    end else if (i == `HSF_IDX_SAVE) begin
      sv = x;
    end else if (op && cm.exists(i) && in_range(i, x)) begin
      // Scale groups keep only the low four bits of the written word
      st[i] = (i >= `HSF_IDX_SCALE0) ? x % 16 : x;
    end
  endtask

  task automatic rdc(input int i, input int ex, input string nm);
    u_mst.xfer(1'b0, i[13:0], 32'h0000_0000, rd, sts);
    hung();
    `CHK(nm, ex, rd)
  endtask

  task automatic chk_all();
    foreach (cm[j]) rdc(j, op ? st[j] : cm[j], "cfg");
  endtask

  task automatic chk_ports();
    e = 0;
    for (g = 0; g < `HSF_SCALE_GROUPS; g++) e |= cm[`HSF_IDX_SCALE0 + g] << (4 * g);
    `CHK("scale_o", e, scale_o)
    `CHK("mode_o", cm[`HSF_IDX_MODE], harm_mode_o)
    `CHK("v_fmt_o", cm[`HSF_IDX_VFMT], v_fmt_o)
    `CHK("i_fmt_o", cm[`HSF_IDX_CFMT], i_fmt_o)
    `CHK("float_o", cm[`HSF_IDX_FEN], float_active_o)
  endtask

  // ============================================================
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    meter_cycle_i = 1'b0;
    harm_done_i = 1'b0;
    meas_ia_i = 32'sh0000_0000;
    float_ia_i = xs();
    button_i = 1'b0;
    cm[`HSF_IDX_MODE] = 1;
    cm[`HSF_IDX_VFMT] = 0;
    cm[`HSF_IDX_CFMT] = 0;
    cm[`HSF_IDX_INTERVAL] = 30;
    cm[`HSF_IDX_FEN] = 0;
    for (g = 0; g < `HSF_SCALE_GROUPS; g++) cm[`HSF_IDX_SCALE0 + g] = 0;
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    chk_all();
    chk_ports();
    `CHK("order", 5'h1F, harm_max_order_o)
    rdc(`HSF_IDX_FLOAT_IA, `HSF_FLOAT_OFF, "float_off");
    wr(`HSF_IDX_MODE, 2);
    rdc(`HSF_IDX_MODE, cm[`HSF_IDX_MODE], "closed");
    u_mst.xfer(1'b0, 14'h0001, 32'h0000_0000, rd, sts);
    hung();
    `CHK("unmapped", 1, sts)
    // Clamping of the stored integer
    iv = '{40000, -40000, int'(xs() % 30000)};
    foreach (iv[j]) begin
      meas_ia_i <= iv[j];
      meter_cycle_i <= 1'b1;
      @(posedge clk_sys_i);
      meter_cycle_i <= 1'b0;
      e = iv[j] > 32767 ? 32767 : (iv[j] < -32767 ? -32767 : iv[j]);
      rdc(`HSF_IDX_IA_INT, e & 32'h0000_FFFF, "ia_int");
      if (j == 2) `CHK("true_val", iv[j], $signed(rd[15:0]) * 10 ** cm[`HSF_IDX_SCALE0])
    end
    // Harmonic run after the countdown expires
    for (n = 0; n < 1000 && harm_start_o !== 1'b1; n++) @(posedge clk_sys_i);
    `CHK("start", 1, n < 1000)
    if (n >= 1000) give_verdict();
    rdc(`HSF_IDX_DONE, 0, "done0");
    rdc(`HSF_IDX_RFLAG, 0, "flag0");
    u_mst.xfer(1'b0, `HSF_IDX_CDOWN, 32'h0000_0000, rd, sts);
    hung();
    `CHK("cdown", 1'b1, rd <= 30)
    harm_done_i <= 1'b1;
    @(posedge clk_sys_i);
    harm_done_i <= 1'b0;
    rdc(`HSF_IDX_DONE, 1, "done1");
    rdc(`HSF_IDX_RFLAG, 1, "flag1");
    `CHK("freeze", 0, harm_freeze_o)
    // Sessions: first discarded, second committed
    for (r = 0; r < 2; r++) begin
      wr(`HSF_IDX_CMD, `HSF_CMD_ENTER);
      for (k = 0; k < 16; k++) begin
        idx = (k % 8 < 4) ? `HSF_IDX_MODE + k % 4 : `HSF_IDX_SCALE0 + k % 4;
        v = (idx == `HSF_IDX_INTERVAL) ? xs() % 64 : xs() % (idx >= `HSF_IDX_SCALE0 ? 17 : 4);
        wr(idx, v);
        if (k == 8) wr(`HSF_IDX_CMD, `HSF_CMD_ENTER);
      end
      chk_all();
      wr(`HSF_IDX_SAVE, r ? 1 : 2);
      wr(`HSF_IDX_CMD, `HSF_CMD_EXIT);
      chk_all();
      chk_ports();
    end
    // Float set activation
    wr(`HSF_IDX_CMD, `HSF_CMD_ENTER);
    wr(`HSF_IDX_FEN, 1);
    wr(`HSF_IDX_SAVE, 1);
    wr(`HSF_IDX_CMD, `HSF_CMD_EXIT);
    rdc(`HSF_IDX_FLOAT_IA, float_ia_i, "float_on");
    chk_ports();
    `CHK("disp_int", 1'b1, disp_int_fmt_o)
    // Idle session is abandoned
    wr(`HSF_IDX_CMD, `HSF_CMD_ENTER);
    wr(`HSF_IDX_VFMT, (cm[`HSF_IDX_VFMT] + 1) % 3);
    for (n = 0; n < 2000 && setup_open_o === 1'b1; n++) @(posedge clk_sys_i);
    op = 0;
    `CHK("abandon", 1'b1, n > 110 * SEC && n < 2000)
    if (n >= 2000) give_verdict();
    chk_all();
    give_verdict();
  end
endmodule

`default_nettype wire
